// ===== rtl/wpba_pkg.sv
// shared types and constants for the weighted priority bandwidth arbiter
`default_nettype none
package wpba_pkg;
    localparam int unsigned NUM_REQ = 6;
    localparam int unsigned NUM_RES = 4;
    localparam int unsigned PRIO_W = 4;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned IDX_W = 3;
    localparam int unsigned EFF_W = 5;
    localparam logic [PRIO_W-1:0] PRIO_MOST = 4'h0;
    localparam logic [PRIO_W-1:0] PRIO_LEAST = 4'h8;
    // effective priority: 0 = escalated (-1), 1..9 = level 0..8, 1f = no request
    localparam logic [EFF_W-1:0] EFF_ESC = 5'h00;
    localparam logic [EFF_W-1:0] EFF_NONE = 5'h1f;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [IDX_W-1:0] IDX_ZERO = 3'h0;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h5;

    // requesters, in index order
    localparam logic [IDX_W-1:0] REQ_SYSTEM_DMA = 3'h0;
    localparam logic [IDX_W-1:0] REQ_INTERNAL_DMA = 3'h1;
    localparam logic [IDX_W-1:0] REQ_BLOCK_COH = 3'h2;
    localparam logic [IDX_W-1:0] REQ_GLOBAL_COH = 3'h3;
    localparam logic [IDX_W-1:0] REQ_CPU_DATA = 3'h4;
    localparam logic [IDX_W-1:0] REQ_CPU_PROG = 3'h5;

    // resources: level1_program_memory, level1_data_memory, level2_memory, config bus
    typedef struct packed {
        logic valid;
        logic [PRIO_W-1:0] prio;
    } wpba_req_type;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] idx;
    } wpba_gnt_type;
endpackage
`default_nettype wire

// ===== rtl/wpba_res_arb.sv
// one resource arbiter: priority pick, rotating ties, contention counter
`default_nettype none
module wpba_res_arb (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // configuration
    input wire logic [wpba_pkg::CNT_W-1:0] i_n,
    input wire logic i_fixed_en,
    input wire logic [wpba_pkg::IDX_W-1:0] i_fixed_idx,
    // requests
    input wire wpba_pkg::wpba_req_type [wpba_pkg::NUM_REQ-1:0] i_req,
    // grant
    output logic [wpba_pkg::NUM_REQ-1:0] o_gnt_vec,
    output wpba_pkg::wpba_gnt_type o_gnt
);
    localparam int N = wpba_pkg::NUM_REQ;
    logic [wpba_pkg::IDX_W-1:0] rr_q;
    logic [wpba_pkg::IDX_W-1:0] rr_d;
    logic [wpba_pkg::CNT_W-1:0] cnt_q;
    logic [wpba_pkg::CNT_W-1:0] cnt_d;
    logic [wpba_pkg::IDX_W-1:0] low_q;
    logic [wpba_pkg::IDX_W-1:0] low_d;
    logic [wpba_pkg::EFF_W-1:0] base [N];
    logic [wpba_pkg::EFF_W-1:0] eff [N];
    logic [wpba_pkg::EFF_W-1:0] best_eff;
    logic [wpba_pkg::EFF_W-1:0] best_base;
    logic [wpba_pkg::IDX_W-1:0] win;
    logic [wpba_pkg::IDX_W-1:0] low_start;
    logic [N-1:0] req_vld;
    logic [N-1:0] loser;
    logic [N-1:0] at_best;
    logic [N-1:0] outranks;
    logic any_req;
    logic contend;
    logic expired;
    logic esc_grant;
    logic win_esc;
    logic tie;

    // level 0..8 maps to 1..9 so escalation (-1) sits below every level
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (!i_req[i].valid) begin
                base[i] = wpba_pkg::EFF_NONE;
            end else if (i_fixed_en && i_fixed_idx == i[wpba_pkg::IDX_W-1:0]) begin
                base[i] = wpba_pkg::EFF_ESC;
            end else begin
                base[i] = {1'b0, i_req[i].prio} + 5'h01;
            end
            eff[i] = (expired && low_q == i[wpba_pkg::IDX_W-1:0] && i_req[i].valid)
                ? wpba_pkg::EFF_ESC : base[i];
        end
    end

    // most urgent wins; among equals the first at or after rr_q wins
    always_comb begin
        logic [wpba_pkg::IDX_W-1:0] k;
        k = rr_q;
        best_eff = wpba_pkg::EFF_NONE;
        best_base = wpba_pkg::EFF_NONE;
        win = wpba_pkg::IDX_ZERO;
        for (int j = 0; j < N; j++) begin
            if (eff[k] < best_eff) begin
                best_eff = eff[k];
                win = k;
            end
            if (base[k] < best_base) begin
                best_base = base[k];
            end
            k = (k == wpba_pkg::IDX_LAST) ? wpba_pkg::IDX_ZERO : k + 3'h1;
        end
    end

    // a loser is a live request whose base level is worse than the best base level; tied requests are not losers
    for (genvar g = 0; g < N; g++) begin : g_flag
        assign req_vld[g] = i_req[g].valid;
        assign loser[g] = (base[g] != wpba_pkg::EFF_NONE) && (base[g] != best_base);
        assign at_best[g] = (eff[g] != wpba_pkg::EFF_NONE) && (eff[g] == best_eff);
        assign outranks[g] = req_vld[g] && (i_req[g].prio < i_req[win].prio);
    end

    // escalation target steps through the losers in turn, so a middle-level
    // loser is not starved behind the least urgent one
    assign low_start = !esc_grant ? low_q
        : (low_q == wpba_pkg::IDX_LAST) ? wpba_pkg::IDX_ZERO : low_q + 3'h1;

    always_comb begin
        logic [wpba_pkg::IDX_W-1:0] m;
        logic hit;
        m = low_start;
        hit = 1'b0;
        low_d = low_q;
        for (int j = 0; j < N; j++) begin
            if (!hit && loser[m]) begin
                low_d = m;
                hit = 1'b1;
            end
            m = (m == wpba_pkg::IDX_LAST) ? wpba_pkg::IDX_ZERO : m + 3'h1;
        end
    end

    assign any_req = (best_eff != wpba_pkg::EFF_NONE);
    assign contend = |loser;
    assign expired = (cnt_q == wpba_pkg::CNT_ZERO);
    assign esc_grant = expired && loser[low_q] && (win == low_q);
    assign win_esc = (i_fixed_en && i_fixed_idx == win) || (expired && low_q == win);
    assign tie = ($countones(at_best) > 1);
    assign rr_d = !any_req ? rr_q
        : (win == wpba_pkg::IDX_LAST) ? wpba_pkg::IDX_ZERO : win + 3'h1;

    // count down while a loser waits; reload on escalated grant
    always_comb begin
        if (esc_grant || !contend) begin
            cnt_d = (i_n == wpba_pkg::CNT_ZERO) ? wpba_pkg::CNT_ZERO : i_n - 8'h01;
        end else if (!expired) begin
            cnt_d = cnt_q - wpba_pkg::CNT_ONE;
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rr_q <= wpba_pkg::IDX_ZERO;
            cnt_q <= wpba_pkg::CNT_ZERO;
            low_q <= wpba_pkg::IDX_ZERO;
        end else begin
            rr_q <= rr_d;
            cnt_q <= cnt_d;
            low_q <= low_d;
        end
    end

    always_comb begin
        o_gnt_vec = '0;
        if (any_req) begin
            o_gnt_vec[win] = 1'b1;
        end
    end
    assign o_gnt.valid = any_req;
    assign o_gnt.idx = win;

    one_grant_a: assert property (@(posedge i_clk) disable iff (i_srst)
        $onehot0(o_gnt_vec)) else $error("more than one grant");
    granted_valid_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_gnt.valid |-> req_vld[o_gnt.idx]) else $error("grant to idle requester");
    best_wins_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_gnt.valid && !win_esc |-> outranks == '0) else $error("not most urgent");
    reload_a: assert property (@(posedge i_clk) disable iff (i_srst)
        esc_grant && i_n != wpba_pkg::CNT_ZERO |=> cnt_q == $past(i_n) - wpba_pkg::CNT_ONE)
        else $error("counter not reloaded");
    count_down_a: assert property (@(posedge i_clk) disable iff (i_srst)
        contend && !expired |=> cnt_q == $past(cnt_q) - wpba_pkg::CNT_ONE)
        else $error("counter stalled");
    esc_wins_a: assert property (@(posedge i_clk) disable iff (i_srst)
        expired && loser[low_q] && !i_fixed_en |-> o_gnt.idx == low_q)
        else $error("escalated loser lost");
    fixed_wins_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_fixed_en && i_fixed_idx <= wpba_pkg::IDX_LAST && req_vld[i_fixed_idx] && !expired
        |-> o_gnt.idx == i_fixed_idx) else $error("fixed requester lost");
    no_req_a: assert property (@(posedge i_clk) disable iff (i_srst)
        req_vld == '0 |-> !o_gnt.valid) else $error("grant without request");
    rotate_a: assert property (@(posedge i_clk) disable iff (i_srst)
        tie ##1 (tie && $stable(at_best)) |-> o_gnt.idx != $past(o_gnt.idx))
        else $error("tie rotation broken");
endmodule
`default_nettype wire

// ===== rtl/wpba_top.sv
// weighted priority bandwidth arbiter over four shared resources
// Functional notes
// - six requesters: DMAs, coherency, CPU accesses
// - separate arbiter per shared resource
// - no requester holds a resource forever
// - priority value means same everywhere
// - nine levels, zero most urgent
// - most urgent contending request wins
// - loser granted once every n cycles
// - expiry or fixed setting gives priority -1
`default_nettype none
module wpba_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // configuration, one per resource
    input wire logic [wpba_pkg::NUM_RES-1:0][wpba_pkg::CNT_W-1:0] i_contention_n,
    input wire logic [wpba_pkg::NUM_RES-1:0] i_fixed_en,
    input wire logic [wpba_pkg::NUM_RES-1:0][wpba_pkg::IDX_W-1:0] i_fixed_idx,
    // requests: each requester names one resource per transfer
    input wire wpba_pkg::wpba_req_type [wpba_pkg::NUM_REQ-1:0] i_req,
    input wire logic [wpba_pkg::NUM_REQ-1:0][1:0] i_req_res,
    // grants
    output logic [wpba_pkg::NUM_REQ-1:0] o_req_gnt,
    output wpba_pkg::wpba_gnt_type [wpba_pkg::NUM_RES-1:0] o_res_gnt
);
    wpba_pkg::wpba_req_type [wpba_pkg::NUM_RES-1:0][wpba_pkg::NUM_REQ-1:0] route;
    logic [wpba_pkg::NUM_RES-1:0][wpba_pkg::NUM_REQ-1:0] gvec;

    // steer each request of level 0..8, with its own priority, to its resource; higher values are dropped
    always_comb begin
        for (int r = 0; r < wpba_pkg::NUM_RES; r++) begin
            for (int q = 0; q < wpba_pkg::NUM_REQ; q++) begin
                route[r][q].valid = i_req[q].valid && (i_req_res[q] == r[1:0])
                    && (i_req[q].prio <= wpba_pkg::PRIO_LEAST);
                route[r][q].prio = i_req[q].prio;
            end
        end
    end

    for (genvar g = 0; g < wpba_pkg::NUM_RES; g++) begin : g_res
        wpba_res_arb u_arb (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_n(i_contention_n[g]),
            .i_fixed_en(i_fixed_en[g]),
            .i_fixed_idx(i_fixed_idx[g]),
            .i_req(route[g]),
            .o_gnt_vec(gvec[g]),
            .o_gnt(o_res_gnt[g])
        );
    end

    always_comb begin
        o_req_gnt = '0;
        for (int r = 0; r < wpba_pkg::NUM_RES; r++) begin
            o_req_gnt = o_req_gnt | gvec[r];
        end
    end

    gnt_needs_req_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (o_req_gnt & ~{i_req[5].valid, i_req[4].valid, i_req[3].valid,
        i_req[2].valid, i_req[1].valid, i_req[0].valid}) == '0)
        else $error("grant without request");
endmodule
`default_nettype wire

// ===== bench/wpba_req_model.sv
// requester side model: per-transfer levels, idle lines scrambled
`default_nettype none
module wpba_req_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // commanded transfers
    input wire wpba_pkg::wpba_req_type [5:0] i_cmd,
    input wire logic [5:0][1:0] i_cmd_res,
    // request lines to the arbiter
    output wpba_pkg::wpba_req_type [5:0] o_req,
    output logic [5:0][1:0] o_req_res
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0][5:0] last_q;
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < 6; i++) begin
            if (i_srst) begin
                last_q[i] <= 6'h00;
            end else if (i_cmd[i].valid) begin
                last_q[i] <= {i_cmd[i].prio, i_cmd_res[i]};
            end
        end
    end
    // an idle requester shows the inverse of its last level and target
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            o_req[i].valid = i_cmd[i].valid;
            {o_req[i].prio, o_req_res[i]} = i_cmd[i].valid ?
                {i_cmd[i].prio, i_cmd_res[i]} : ~last_q[i];
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the weighted priority bandwidth arbiter
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [3:0][7:0] i_contention_n = {4{8'hff}};
    logic [3:0] i_fixed_en = 4'h0;
    logic [3:0][2:0] i_fixed_idx = '0;
    wpba_pkg::wpba_req_type [5:0] cmd = '0;
    wpba_pkg::wpba_req_type [5:0] nxt = '0;
    wpba_pkg::wpba_req_type [5:0] req;
    logic [5:0][1:0] cmd_res = '0;
    logic [5:0][1:0] nxt_res = '0;
    logic [5:0][1:0] req_res;
    logic [5:0] req_gnt;
    wpba_pkg::wpba_gnt_type [3:0] res_gnt;
    logic [5:0] expq[$];
    logic [5:0] e;
    logic [3:0] got;
    logic [5:0] gexp;
    int miscompares = 0;
    int n_compared = 0;
    int seed = 32'ha2c7c508;
    int a;
    int b;
    always #10 i_clk = ~i_clk;
    wpba_req_model model (.i_clk(i_clk), .i_srst(i_srst), .i_cmd(cmd), .i_cmd_res(cmd_res),
        .o_req(req), .o_req_res(req_res));
    wpba_top DUT (.i_clk(i_clk), .i_srst(i_srst), .i_contention_n(i_contention_n),
        .i_fixed_en(i_fixed_en), .i_fixed_idx(i_fixed_idx), .i_req(req),
        .i_req_res(req_res), .o_req_gnt(req_gnt), .o_res_gnt(res_gnt));
    task automatic wrap_up;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // stage two requests on one resource; b of 6 means a lone request
    task automatic set2(input int a, input int pa, input int b, input int pb, input int r);
        nxt = '0;
        nxt_res = '0;
        nxt[a] = {1'b1, 4'(pa)};
        nxt_res[a] = 2'(r);
        if (b < 6) begin
            nxt[b] = {1'b1, 4'(pb)};
            nxt_res[b] = 2'(r);
        end
    endtask
    task automatic go(input logic chk, input logic [5:0] exp);
        @(posedge i_clk);
        cmd <= nxt;
        cmd_res <= nxt_res;
        if (chk) begin
            expq.push_back(exp);
        end
    endtask
    // grants are combinational, so compare mid-cycle
    always @(negedge i_clk) begin
        if (expq.size() > 0) begin
            e = expq.pop_front();
            got = {res_gnt[e[5:4]].valid, res_gnt[e[5:4]].idx};
            gexp = e[3] ? (6'h01 << e[2:0]) : 6'h00;
            n_compared++;
            if (got[3] !== e[3] || (e[3] && got[2:0] !== e[2:0]) || req_gnt !== gexp) begin
                miscompares++;
                $display("[FAIL] t=%0t exp=%h/%h got=%h/%h", $time, e[3:0], gexp, got, req_gnt);
            end
        end
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        go(0, 0);
        go(0, 0);
        for (int r = 0; r < 4; r++) begin
            for (int p = 0; p < 8; p++) begin
                a = {$random(seed)} % 6;
                b = (a + 1 + {$random(seed)} % 5) % 6;
                set2(a, p, b, p + 1, r);
                go(1, {2'(r), 1'b1, 3'(a)});
            end
        end
        set2(2, 9, 6, 0, 0);
        go(1, 6'h00);
        set2(2, 8, 6, 0, 0);
        go(1, 6'h0a);
        nxt = '0;
        i_contention_n[2] <= 8'h03;
        go(0, 0);
        go(0, 0);
        set2(0, 2, 4, 5, 2);
        for (int k = 0; k < 6; k++) begin
            go(1, (k % 3 == 2) ? 6'h2c : 6'h28);
        end
        nxt = '0;
        i_fixed_en <= 4'h2;
        i_fixed_idx[1] <= 3'h5;
        go(0, 0);
        set2(5, 8, 1, 0, 1);
        go(1, 6'h1d);
        set2(1, 0, 6, 0, 1);
        go(1, 6'h19);
        set2(3, 3, 6, 0, 3);
        go(1, 6'h3b);
        set2(1, 3, 3, 3, 3);
        go(1, 6'h39);
        go(1, 6'h3b);
        go(1, 6'h39);
        nxt = '0;
        go(0, 0);
        go(0, 0);
        wrap_up();
    end
endmodule
`default_nettype wire
